// ### bsio_pkg.sv
// Shared constants, carrier types and helpers of the bus-shared I/O ports.
package bsio_pkg;

    // Width of the Avalon byte address; word index sits in bits 5:2.
    localparam int ADDR_W = 6;

    // Register indexes; the byte address is four times the index.
    localparam logic [3:0] IDX_A_DATA = 4'h0;
    localparam logic [3:0] IDX_B_DATA = 4'h1;
    localparam logic [3:0] IDX_A_DIR = 4'h2;
    localparam logic [3:0] IDX_B_DIR = 4'h4;
    localparam logic [3:0] IDX_B_FN = 4'h5;
    localparam logic [3:0] IDX_C_DATA = 4'h6;
    localparam logic [3:0] IDX_C_DIR = 4'h8;
    localparam logic [3:0] IDX_C_FN = 4'h9;

    // Reset values of the port registers.
    localparam logic [7:0] RST_A_LATCH = 8'h00;
    localparam logic [7:0] RST_B_LATCH = 8'h00;
    localparam logic [7:0] RST_C_LATCH = 8'hFF;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_FN = 8'h00;

    // Per-pin selection codes, function bit above direction bit.
    localparam logic [1:0] SEL_INPUT = 2'h0;
    localparam logic [1:0] SEL_OUTPUT = 2'h1;
    localparam logic [1:0] SEL_ALT0 = 2'h2;
    localparam logic [1:0] SEL_ALT1 = 2'h3;

    // Signals handed over by the external bus controller.
    typedef struct packed {
        logic access;       // An external area access is in progress.
        logic [23:0] addr;  // Full external address.
        logic [15:0] ad_out; // Multiplexed address/data to drive.
        logic ad_low_oe;    // Controller drives the low byte.
        logic ad_high_oe;   // Controller drives the high byte.
    } bsio_ext_bus_t;

    // Output level and drive enable of one eight-pin port.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } bsio_pins_t;

    // Complete state of the top module.
    typedef struct packed {
        logic [7:0] lat_a;
        logic [7:0] dir_a;
        logic [7:0] lat_b;
        logic [7:0] dir_b;
        logic [7:0] fn_b;
        logic [7:0] lat_c;
        logic [7:0] dir_c;
        logic [7:0] fn_c;
        logic waitrequest;
        logic [31:0] readdata;
        bsio_pins_t pins_a;
        bsio_pins_t pins_b;
        bsio_pins_t pins_c;
    } bsio_state_t;

    // Word index of a byte address.
    function automatic logic [3:0] bsio_reg_index(logic [ADDR_W-1:0] a);
        return a[5:2];
    endfunction : bsio_reg_index

    // A register access must be word aligned.
    function automatic logic bsio_aligned(logic [ADDR_W-1:0] a);
        return a[1:0] == 2'h0;
    endfunction : bsio_aligned

endpackage : bsio_pkg

// ### bsio_sync.sv
// Two-flop synchroniser for the pin levels.
module bsio_sync #(
    parameter int WIDTH = 24
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // Both stages; only the second stage is read outside this module.
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } bsio_sync_state_t;

    bsio_sync_state_t st;      // Registered stages.
    bsio_sync_state_t next_st; // Next value of the stages.

    // Shift the pins through the two stages.
    always_comb
    begin
        next_st = st;
        next_st.meta = async_in;
        next_st.sync = st.meta;
    end

    // Register the stages; reset takes constants only.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sync_out = st.sync;

endmodule : bsio_sync

// ### bsio_pin_mux.sv
// Per-pin selection of input, latch output or one of two bus functions.
module bsio_pin_mux (
    input wire logic [7:0] func,
    input wire logic [7:0] dir,
    input wire logic [7:0] latch,
    input wire logic [7:0] alt0_out,
    input wire logic [7:0] alt0_oe,
    input wire logic [7:0] alt1_out,
    input wire logic [7:0] alt1_oe,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);

    // Each pin picks its source from its own function and direction bit.
    always_comb
    begin
        pin_out = 8'h00;
        pin_oe = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            case ({func[i], dir[i]})
                bsio_pkg::SEL_INPUT:
                begin
                    // Input pins float so the outside can drive them.
                    pin_out[i] = 1'b0;
                    pin_oe[i] = 1'b0;
                end
                bsio_pkg::SEL_OUTPUT:
                begin
                    // Output pins show the latch.
                    pin_out[i] = latch[i];
                    pin_oe[i] = 1'b1;
                end
                bsio_pkg::SEL_ALT0:
                begin
                    pin_out[i] = alt0_out[i];
                    pin_oe[i] = alt0_oe[i];
                end
                bsio_pkg::SEL_ALT1:
                begin
                    pin_out[i] = alt1_out[i];
                    pin_oe[i] = alt1_oe[i];
                end
                default:
                begin
                    pin_out[i] = 1'b0;
                    pin_oe[i] = 1'b0;
                end
            endcase
        end
    end

endmodule : bsio_pin_mux

// ### bsio_ports.sv
// Three general-purpose ports shared with the external address/data bus.
//
// Notes on behaviour
// - First port: eight pins, one direction bit each.
// - Reset clears first port direction to inputs.
// - External access: first port carries address/data, direction cleared.
// - First latch undefined at reset; reads return pins.
// - Second port pins configured individually by two bits.
// - Reset clears second latch, direction, function.
// - Port two: input, output, muxed high, byte one.
// - Reset sets third latch ones, clears direction, function.
// - Third port: input, output, address byte zero, byte two.
// - Data reads return pins; writes load the latch.
//
// Register access over Avalon-MM was chosen for this implementation.
module bsio_ports (
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM slave.
    input wire logic [bsio_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // External bus controller, same clock.
    input wire bsio_pkg::bsio_ext_bus_t ext_bus,
    output logic [15:0] ext_data_in,
    // Pins, as level in, level out and drive enable.
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_c_in,
    output bsio_pkg::bsio_pins_t port_a,
    output bsio_pkg::bsio_pins_t port_b,
    output bsio_pkg::bsio_pins_t port_c
);

    bsio_pkg::bsio_state_t st;      // All registered state.
    bsio_pkg::bsio_state_t next_st; // Next value of the state.

    logic [23:0] pins_sync;         // Synchronised pin levels, C:B:A.
    logic [3:0] reg_idx;            // Word index of the current access.
    logic reg_ok;                   // Access is word aligned.
    logic [7:0] read_byte;          // Value that a read would return.
    bsio_pkg::bsio_pins_t mux_a;    // Pin drive wanted by port A.
    bsio_pkg::bsio_pins_t mux_b;    // Pin drive wanted by port B.
    bsio_pkg::bsio_pins_t mux_c;    // Pin drive wanted by port C.
    logic [7:0] dir_a_eff;          // Port A direction as the pins see it.

    // Pins arrive from outside the clock domain and are synchronised first.
    bsio_sync #(
        .WIDTH(24)
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .async_in({port_c_in, port_b_in, port_a_in}),
        .sync_out(pins_sync)
    );

    assign reg_idx = bsio_pkg::bsio_reg_index(address);
    assign reg_ok = bsio_pkg::bsio_aligned(address);

    // An external access hides the direction bits at once, before the
    // registered clear lands, so that no pin fights the bus.
    assign dir_a_eff = st.dir_a & ~{8{ext_bus.access}};

    // Port A: internal access gives input/output, external gives muxed low.
    bsio_pin_mux u_mux_a (
        .func({8{ext_bus.access}}),
        .dir(dir_a_eff),
        .latch(st.lat_a),
        .alt0_out(ext_bus.ad_out[7:0]),
        .alt0_oe({8{ext_bus.ad_low_oe}}),
        .alt1_out(8'h00),
        .alt1_oe(8'h00),
        .pin_out(mux_a.out),
        .pin_oe(mux_a.oe)
    );

    // Port B: muxed high byte or address byte one as bus functions.
    bsio_pin_mux u_mux_b (
        .func(st.fn_b),
        .dir(st.dir_b),
        .latch(st.lat_b),
        .alt0_out(ext_bus.ad_out[15:8]),
        .alt0_oe({8{ext_bus.ad_high_oe}}),
        .alt1_out(ext_bus.addr[15:8]),
        .alt1_oe(8'hFF),
        .pin_out(mux_b.out),
        .pin_oe(mux_b.oe)
    );

    // Port C: address byte zero or byte two. A function bit set while its
    // direction bit is still clear shows byte zero on that pin meanwhile.
    bsio_pin_mux u_mux_c (
        .func(st.fn_c),
        .dir(st.dir_c),
        .latch(st.lat_c),
        .alt0_out(ext_bus.addr[7:0]),
        .alt0_oe(8'hFF),
        .alt1_out(ext_bus.addr[23:16]),
        .alt1_oe(8'hFF),
        .pin_out(mux_c.out),
        .pin_oe(mux_c.oe)
    );

    // Read value for the addressed register. Data registers return the pin
    // levels, not the latch; write-only registers read as zero.
    always_comb
    begin
        read_byte = 8'h00;
        if (reg_ok)
        begin
            case (reg_idx)
                bsio_pkg::IDX_A_DATA: read_byte = pins_sync[7:0];
                bsio_pkg::IDX_B_DATA: read_byte = pins_sync[15:8];
                bsio_pkg::IDX_C_DATA: read_byte = pins_sync[23:16];
                default: read_byte = 8'h00;
            endcase
        end
    end

    // Next state: bus handshake, register writes, and pin drive.
    always_comb
    begin
        next_st = st;
        // Waitrequest drops for one cycle after each new request, so every
        // access takes two cycles and back-to-back accesses are allowed.
        next_st.waitrequest = !((read || write) && st.waitrequest);
        if (read && st.waitrequest)
        begin
            next_st.readdata = {24'h000000, read_byte};
        end
        // Writes take effect at the edge where waitrequest is seen low.
        // Unmapped or misaligned writes are dropped without error.
        if (write && !st.waitrequest && reg_ok && byteenable[0])
        begin
            case (reg_idx)
                bsio_pkg::IDX_A_DATA: next_st.lat_a = writedata[7:0];
                bsio_pkg::IDX_B_DATA: next_st.lat_b = writedata[7:0];
                bsio_pkg::IDX_C_DATA: next_st.lat_c = writedata[7:0];
                bsio_pkg::IDX_A_DIR: next_st.dir_a = writedata[7:0];
                bsio_pkg::IDX_B_DIR: next_st.dir_b = writedata[7:0];
                bsio_pkg::IDX_B_FN: next_st.fn_b = writedata[7:0];
                bsio_pkg::IDX_C_DIR: next_st.dir_c = writedata[7:0];
                bsio_pkg::IDX_C_FN: next_st.fn_c = writedata[7:0];
                default: next_st.lat_a = st.lat_a;
            endcase
        end
        // The bus clear is hardware's and overrides a software write.
        if (ext_bus.access)
        begin
            next_st.dir_a = bsio_pkg::RST_DIR;
        end
        // Pins are driven from flops; they follow the selection one cycle late.
        next_st.pins_a = mux_a;
        next_st.pins_b = mux_b;
        next_st.pins_c = mux_c;
    end

    // Register the state. The port A latch has no meaningful reset value;
    // it is given one only so the flops are never unknown.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.lat_a <= bsio_pkg::RST_A_LATCH;
            st.dir_a <= bsio_pkg::RST_DIR;
            st.lat_b <= bsio_pkg::RST_B_LATCH;
            st.dir_b <= bsio_pkg::RST_DIR;
            st.fn_b <= bsio_pkg::RST_FN;
            st.lat_c <= bsio_pkg::RST_C_LATCH;
            st.dir_c <= bsio_pkg::RST_DIR;
            st.fn_c <= bsio_pkg::RST_FN;
            st.waitrequest <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flops.
    assign readdata = st.readdata;
    assign waitrequest = st.waitrequest;
    assign port_a = st.pins_a;
    assign port_b = st.pins_b;
    assign port_c = st.pins_c;
    assign ext_data_in = pins_sync[15:0];

    // Checks on the behaviour above.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // The bus takeover clears port A direction at the next edge.
    ext_dir_clear_a: assert property (
        ext_bus.access |=> st.dir_a == 8'h00)
        else $error("Port A direction not cleared by external access.");

    // During the takeover port A carries the low muxed byte.
    ext_ad_low_a: assert property (
        ext_bus.access |=> port_a.out == $past(ext_bus.ad_out[7:0])
            && port_a.oe == {8{$past(ext_bus.ad_low_oe)}})
        else $error("Port A does not carry the low address/data byte.");

    // Away from the bus, port A drive follows its direction bits.
    port_a_dir_a: assert property (
        (!ext_bus.access && !$past(ext_bus.access))
            |=> port_a.oe == $past(st.dir_a))
        else $error("Port A drive does not follow its direction bits.");

    // Reset values of the port A direction and the port B registers.
    reset_a_dir_a: assert property (
        @(posedge clock) disable iff (1'b0)
        $rose(rstn) |-> st.dir_a == 8'h00 && st.dir_b == 8'h00
            && st.fn_b == 8'h00 && st.lat_b == 8'h00)
        else $error("Port A or B registers wrong after reset.");

    // Reset values of the port C registers.
    reset_c_regs_a: assert property (
        @(posedge clock) disable iff (1'b0)
        $rose(rstn) |-> st.lat_c == 8'hFF && st.dir_c == 8'h00
            && st.fn_c == 8'h00)
        else $error("Port C registers wrong after reset.");

    // Port B on address byte one.
    port_b_addr_a: assert property (
        (st.fn_b == 8'hFF && st.dir_b == 8'hFF)
            |=> port_b.oe == 8'hFF && port_b.out == $past(ext_bus.addr[15:8]))
        else $error("Port B does not show address byte one.");

    // Port C on address byte two.
    port_c_top_a: assert property (
        (st.fn_c == 8'hFF && st.dir_c == 8'hFF)
            |=> port_c.oe == 8'hFF
            && port_c.out == $past(ext_bus.addr[23:16]))
        else $error("Port C does not show address byte two.");

    // Port C output mode drives the latch.
    port_c_out_a: assert property (
        (st.fn_c == 8'h00 && st.dir_c == 8'hFF)
            |=> port_c.oe == 8'hFF && port_c.out == $past(st.lat_c))
        else $error("Port C output mode does not drive the latch.");

    // Port B data reads return the synchronised pins.
    data_read_a: assert property (
        (read && waitrequest && reg_ok && reg_idx == bsio_pkg::IDX_B_DATA)
            |=> !waitrequest
            && readdata == {24'h000000, $past(pins_sync[15:8])})
        else $error("Port B data read does not return the pins.");

    // A direction write lands at the completing edge.
    dir_write_a: assert property (
        (write && !waitrequest && reg_ok && byteenable[0]
            && reg_idx == bsio_pkg::IDX_B_DIR)
            |=> st.dir_b == $past(writedata[7:0]))
        else $error("Port B direction write lost.");

    // Every access is answered after exactly one wait cycle.
    bus_answer_a: assert property (
        ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("Bus answer not one cycle after the request.");

    // Reset leaves every pin undriven and the bus busy.
    reset_pins_a: assert property (
        @(posedge clock) disable iff (1'b0)
        $rose(rstn) |-> port_a.oe == 8'h00 && port_b.oe == 8'h00
            && port_c.oe == 8'h00 && waitrequest)
        else $error("Pins driven or bus ready right after reset.");

    // Port B output mode drives the latch.
    port_b_out_a: assert property (
        (st.fn_b == 8'h00 && st.dir_b == 8'hFF)
            |=> port_b.oe == 8'hFF && port_b.out == $past(st.lat_b))
        else $error("Port B output mode does not drive the latch.");

    // Port B alternate byte follows the bus controller.
    port_b_ad_a: assert property (
        (st.fn_b == 8'hFF && st.dir_b == 8'h00)
            |=> port_b.out == $past(ext_bus.ad_out[15:8])
            && port_b.oe == {8{$past(ext_bus.ad_high_oe)}})
        else $error("Port B does not carry the high muxed byte.");

    // Port C alternate byte is address byte zero.
    port_c_low_a: assert property (
        (st.fn_c == 8'hFF && st.dir_c == 8'h00)
            |=> port_c.oe == 8'hFF && port_c.out == $past(ext_bus.addr[7:0]))
        else $error("Port C does not show address byte zero.");

    // Input pins float on ports B and C.
    input_float_a: assert property (
        (st.fn_b == 8'h00 && st.dir_b == 8'h00 && st.fn_c == 8'h00
            && st.dir_c == 8'h00)
            |=> port_b.oe == 8'h00 && port_c.oe == 8'h00)
        else $error("Input pins of port B or C are driven.");

    // Port A output mode drives the latch while the bus is idle.
    port_a_out_a: assert property (
        (!ext_bus.access && st.dir_a == 8'hFF)
            |=> port_a.oe == 8'hFF && port_a.out == $past(st.lat_a))
        else $error("Port A output mode does not drive the latch.");

    // Port A data reads return the pins, not the latch.
    port_a_read_a: assert property (
        (read && waitrequest && reg_ok && reg_idx == bsio_pkg::IDX_A_DATA)
            |=> readdata == {24'h000000, $past(pins_sync[7:0])})
        else $error("Port A data read does not return the pins.");

    // Latch writes land when waitrequest is seen low.
    latch_write_a: assert property (
        (write && !waitrequest && reg_ok && byteenable[0]
            && reg_idx == bsio_pkg::IDX_C_DATA)
            |=> st.lat_c == $past(writedata[7:0]))
        else $error("Port C latch write lost.");

    // A write without byte lane zero changes no port B or port C register.
    byte_drop_a: assert property (
        (write && !waitrequest && !byteenable[0])
            |=> $stable(st.lat_b) && $stable(st.dir_b) && $stable(st.fn_b)
            && $stable(st.lat_c) && $stable(st.dir_c) && $stable(st.fn_c))
        else $error("Write with byte lane zero off changed a register.");

    // Write-only registers read as zero.
    wo_read_a: assert property (
        (read && waitrequest && reg_ok && reg_idx == bsio_pkg::IDX_C_FN)
            |=> readdata == 32'h00000000)
        else $error("Port C function register does not read as zero.");

    // No request, no answer.
    bus_idle_a: assert property (
        (!read && !write) |=> waitrequest)
        else $error("Waitrequest dropped without a request.");

    // Covers for the main scenarios.
    ext_access_c: cover property ($rose(ext_bus.access));
    top_addr_c: cover property (st.fn_c == 8'hFF && st.dir_c == 8'hFF);
    read_done_c: cover property (read && !waitrequest);
    write_done_c: cover property (write && !waitrequest);
    ad_high_c: cover property (st.fn_b == 8'hFF && st.dir_b == 8'h00);

endmodule : bsio_ports

// ### bsio_bus_partner.sv
// Model of the memory and peripherals that share the expansion pins.
module bsio_bus_partner (
    input wire bsio_pkg::bsio_pins_t port_a,
    input wire bsio_pkg::bsio_pins_t port_b,
    input wire bsio_pkg::bsio_pins_t port_c,
    input wire logic [7:0] drive_a,
    input wire logic [7:0] drive_b,
    input wire logic [7:0] drive_c,
    output logic [7:0] port_a_in,
    output logic [7:0] port_b_in,
    output logic [7:0] port_c_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // The far side drives every pin that the ports leave floating.
    // A released pin shows the partner's value, never a stale level.
    assign port_a_in = (port_a.out & port_a.oe) | (drive_a & ~port_a.oe);
    assign port_b_in = (port_b.out & port_b.oe) | (drive_b & ~port_b.oe);
    assign port_c_in = (port_c.out & port_c.oe) | (drive_c & ~port_c.oe);
endmodule : bsio_bus_partner

// ### bus_shared_io_ports_bench.sv
// Self-checking bench for the bus-shared I/O ports.
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("unexpected %s expected %h seen %h", nm, e, g); \
        end \
    end

module bus_shared_io_ports_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, rstn, read, write, waitrequest;
    logic [5:0] address;
    logic [31:0] writedata, readdata, rdata_q;
    logic [3:0] byteenable;
    logic [15:0] ext_data_in, exp16;
    logic [7:0] pa_in, pb_in, pc_in, drv_a, drv_b, drv_c;
    logic [7:0] v [8];
    bsio_pkg::bsio_ext_bus_t ext_bus;
    bsio_pkg::bsio_pins_t port_a, port_b, port_c, ea, eb, ec;
    int n_mismatch, n_tests, cycles;

    bsio_ports dut (.clock(clock), .rstn(rstn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .ext_bus(ext_bus),
        .ext_data_in(ext_data_in), .port_a_in(pa_in), .port_b_in(pb_in),
        .port_c_in(pc_in), .port_a(port_a), .port_b(port_b),
        .port_c(port_c));

    bsio_bus_partner far_side (.port_a(port_a), .port_b(port_b),
        .port_c(port_c), .drive_a(drv_a), .drive_b(drv_b),
        .drive_c(drv_c), .port_a_in(pa_in), .port_b_in(pb_in),
        .port_c_in(pc_in));

    // A 200 MHz clock.
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Watchdog: a hang counts as a mismatch and ends the run.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // One Avalon access; the request stands until the rising edge at which
    // waitrequest is sampled low, and read data is taken at that edge.
    task automatic xfer(input logic wr, input logic [5:0] a,
                        input logic [7:0] d);
        @(posedge clock);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= {24'h000000, d};
        do @(posedge clock); while (waitrequest !== 1'b0);
        rdata_q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        xfer(1'b1, {idx, 2'h0}, d);
    endtask : wr

    task automatic rd(input logic [3:0] idx);
        xfer(1'b0, {idx, 2'h0}, 8'h00);
    endtask : rd

    // Lets the register, pin and synchroniser stages land.
    task automatic settle();
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask : settle

    // Expected pin drive from the per-pin function and direction bits.
    function automatic bsio_pkg::bsio_pins_t exp_mux(input logic [7:0] fn,
        input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] a0o,
        input logic [7:0] a0e, input logic [7:0] a1o, input logic [7:0] a1e);
        bsio_pkg::bsio_pins_t r;
        for (int i = 0; i < 8; i++)
        begin
            case ({fn[i], dir[i]})
                2'h0: {r.out[i], r.oe[i]} = 2'h0;
                2'h1: {r.out[i], r.oe[i]} = {lat[i], 1'b1};
                2'h2: {r.out[i], r.oe[i]} = {a0o[i], a0e[i]};
                default: {r.out[i], r.oe[i]} = {a1o[i], a1e[i]};
            endcase
        end
        return r;
    endfunction : exp_mux

    // Pin level: the port's drive where enabled, else the far side's.
    function automatic logic [7:0] pin_lvl(input bsio_pkg::bsio_pins_t e,
        input logic [7:0] drv);
        return (e.out & e.oe) | (drv & ~e.oe);
    endfunction : pin_lvl

    // Compares drive and enable, then reads the pins back as software.
    task automatic check_port(input string nm, input bsio_pkg::bsio_pins_t got,
        input bsio_pkg::bsio_pins_t e, input logic [7:0] drv,
        input logic [3:0] idx);
        `CHK({nm, " oe"}, e.oe, got.oe)
        `CHK({nm, " out"}, e.out & e.oe, got.out & got.oe)
        rd(idx);
        `CHK({nm, " read"}, {24'h0, pin_lvl(e, drv)}, rdata_q)
    endtask : check_port

    // Reset, then the reset state, refused accesses and latch defaults.
    task automatic do_reset();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        settle();
        `CHK("a oe", 8'h00, port_a.oe)
        `CHK("b oe", 8'h00, port_b.oe)
        `CHK("c oe", 8'h00, port_c.oe)
        rd(bsio_pkg::IDX_A_DATA);
        `CHK("a read", {24'h0, drv_a}, rdata_q)
        xfer(1'b0, 6'h0C, 8'h00);
        `CHK("unmapped read", 32'h0, rdata_q)
        // Misaligned and unmapped writes must leave the ports alone.
        xfer(1'b1, 6'h21, 8'hFF);
        xfer(1'b1, 6'h0C, 8'hFF);
        byteenable <= 4'hE;
        wr(bsio_pkg::IDX_C_FN, 8'hFF);
        byteenable <= 4'hF;
        settle();
        `CHK("c oe dropped", 8'h00, port_c.oe)
        wr(bsio_pkg::IDX_C_DIR, 8'hFF);
        wr(bsio_pkg::IDX_B_DIR, 8'hFF);
        settle();
        `CHK("c latch", 8'hFF, port_c.out)
        `CHK("b latch", 8'h00, port_b.out)
        `CHK("b oe out", 8'hFF, port_b.oe)
    endtask : do_reset

    initial
    begin
        rstn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0;
        byteenable = 4'hF;
        ext_bus = '0;
        n_mismatch = 0;
        n_tests = 0;
        cycles = 0;
        void'($urandom(48025));
        drv_a = 8'($urandom);
        drv_b = 8'($urandom);
        drv_c = 8'($urandom);
        do_reset();
        // Random per-pin modes with random bus-controller addresses.
        for (int it = 0; it < 24; it++)
        begin
            foreach (v[k]) v[k] = 8'($urandom);
            // Corner cases first: all pins on the address bytes, then on
            // the alternate byte, then all plain outputs.
            if (it == 0)
                v = '{8{8'hFF}};
            else if (it == 1)
                v = '{8'h0, 8'h3C, 8'h0, 8'hFF, 8'hA5, 8'h0, 8'hFF, 8'h5A};
            else if (it == 2)
                v = '{8'hFF, 8'h96, 8'hFF, 8'h0, 8'h69, 8'hFF, 8'h0, 8'hC3};
            @(posedge clock);
            ext_bus.addr <= 24'($urandom);
            ext_bus.ad_out <= 16'($urandom);
            ext_bus.ad_high_oe <= 1'($urandom);
            drv_a <= 8'($urandom);
            drv_b <= 8'($urandom);
            drv_c <= 8'($urandom);
            wr(bsio_pkg::IDX_A_DIR, v[0]);
            wr(bsio_pkg::IDX_A_DATA, v[1]);
            wr(bsio_pkg::IDX_B_DIR, v[2]);
            wr(bsio_pkg::IDX_B_FN, v[3]);
            wr(bsio_pkg::IDX_B_DATA, v[4]);
            wr(bsio_pkg::IDX_C_DIR, v[5]);
            wr(bsio_pkg::IDX_C_FN, v[6]);
            wr(bsio_pkg::IDX_C_DATA, v[7]);
            settle();
            ea = exp_mux(8'h00, v[0], v[1], 8'h00, 8'h00, 8'h00, 8'h00);
            eb = exp_mux(v[3], v[2], v[4], ext_bus.ad_out[15:8],
                {8{ext_bus.ad_high_oe}}, ext_bus.addr[15:8], 8'hFF);
            ec = exp_mux(v[6], v[5], v[7], ext_bus.addr[7:0], 8'hFF,
                ext_bus.addr[23:16], 8'hFF);
            exp16 = {pin_lvl(eb, drv_b), pin_lvl(ea, drv_a)};
            `CHK("ext data", exp16, ext_data_in)
            check_port("a", port_a, ea, drv_a, bsio_pkg::IDX_A_DATA);
            check_port("b", port_b, eb, drv_b, bsio_pkg::IDX_B_DATA);
            check_port("c", port_c, ec, drv_c, bsio_pkg::IDX_C_DATA);
            rd(bsio_pkg::IDX_C_FN);
            `CHK("c fn read", 32'h0, rdata_q)
        end
        // External access takes port A over and clears its direction.
        wr(bsio_pkg::IDX_A_DIR, 8'hFF);
        wr(bsio_pkg::IDX_A_DATA, 8'h5A);
        @(posedge clock);
        ext_bus.access <= 1'b1;
        ext_bus.ad_out <= 16'hC3A5;
        ext_bus.ad_low_oe <= 1'b1;
        settle();
        `CHK("a ext out", 8'hA5, port_a.out)
        `CHK("a ext oe", 8'hFF, port_a.oe)
        `CHK("ext data a", 8'hA5, ext_data_in[7:0])
        // A software write during the access must lose to the clear.
        wr(bsio_pkg::IDX_A_DIR, 8'hFF);
        @(posedge clock);
        ext_bus.access <= 1'b0;
        settle();
        `CHK("a dir cleared", 8'h00, port_a.oe)
        do_reset();
        give_verdict();
    end
endmodule : bus_shared_io_ports_bench
